// *** shared/ascan_pkg.sv ***
// Shared constants and carriers for the converter scan control block
package ascan_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Analog control word, one field for each scanned control line
    typedef struct packed {
        logic       switchcap_clock;          // Switched-capacitor filter clock
        logic       amp_to_comp_enable;       // Amplifier path to the comparator
        logic       neg_bandgap_enable;       // Band-gap on the comparator's negative side
        logic       adc_power_enable;         // Converter power-on
        logic       amp_power_enable;         // Differential amplifier power-on
        logic [9:0] dac_value;                // Comparison value, bit 0 lowest
        logic       amp_bypass_select;        // Channels 0-3 around the amplifier
        logic       neg_input_ground_enable;  // Negative input tied to ground
        logic       sample_hold;              // Low tracks, high holds
        logic       bandgap_ref_select;       // Band-gap as converter reference
        logic [7:0] channel_select_bit;       // Input multiplexer selects
        logic [2:0] neg_input_select;         // Negative-side multiplexer select
        logic       amp_pass_gate_enable;     // Amplifier pass gate
        logic       latch_precharge_n;        // Low precharges the output latch
        logic       switchcap_probe_enable;   // Amplifier output to channel 4 pin
        logic       amp_quick_settle;         // Settle assist
        logic       supply_ref_select;        // Supply as converter reference
    } ascan_ctrl_s;

    // Scan pins from the test controller, all on the test clock
    typedef struct packed {
        logic tck;
        logic tdi;
        logic capture_dr;
        logic shift_dr;
        logic update_dr;
    } ascan_scan_s;

    ////////////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int unsigned ASCAN_CTRL_W  = $bits(ascan_ctrl_s);
    localparam int unsigned ASCAN_CHAIN_W = ASCAN_CTRL_W + 1;
    localparam int unsigned ASCAN_SCAN_W  = $bits(ascan_scan_s);
    localparam int unsigned ASCAN_SYNC_W  = ASCAN_SCAN_W + 1;
    localparam int unsigned ASCAN_CNT_W   = 16;

    // Idle levels: bypass, hold, mux bit 0, pass gate and precharge high
    localparam ascan_ctrl_s ASCAN_IDLE = '{
        switchcap_clock:         1'h0,
        amp_to_comp_enable:      1'h0,
        neg_bandgap_enable:      1'h0,
        adc_power_enable:        1'h0,
        amp_power_enable:        1'h0,
        dac_value:               10'h000,
        amp_bypass_select:       1'h1,
        neg_input_ground_enable: 1'h0,
        sample_hold:             1'h1,
        bandgap_ref_select:      1'h0,
        channel_select_bit:      8'h01,
        neg_input_select:        3'h0,
        amp_pass_gate_enable:    1'h1,
        latch_precharge_n:       1'h1,
        switchcap_probe_enable:  1'h0,
        amp_quick_settle:        1'h0,
        supply_ref_select:       1'h0
    };

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [11:0] ASCAN_OFS_CTRL    = 12'h000;
    localparam logic [11:0] ASCAN_OFS_STATUS  = 12'h004;
    localparam logic [11:0] ASCAN_OFS_WORD_LO = 12'h008;
    localparam logic [11:0] ASCAN_OFS_WORD_HI = 12'h00C;
    localparam logic [11:0] ASCAN_OFS_COUNT   = 12'h010;

    // Field positions
    localparam int unsigned ASCAN_CTRL_SCAN_EN  = 0;
    localparam int unsigned ASCAN_ST_CONFLICT   = 0;
    localparam int unsigned ASCAN_ST_HOLD_VIOL  = 1;
    localparam int unsigned ASCAN_ST_COMP       = 2;
    localparam int unsigned ASCAN_ST_AMP_ACTIVE = 3;

    // Values after reset
    localparam logic                   ASCAN_RST_SCAN_EN = 1'h1;
    localparam logic [ASCAN_CNT_W-1:0] ASCAN_RST_COUNT   = 16'h0000;

endpackage : ascan_pkg

// *** core/ascan_sync.sv ***
// Two-flop synchroniser for a group of independent levels
`timescale 1ns/100ps
module ascan_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // Levels
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_q;

    ////////////////////////////////////////////////////////////////////////////////
    // One pair of flops per bit; the first is read by the second only
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++)
        begin : g_bit
            always_ff @(posedge clk)
            begin
                if (sys_rst)
                begin
                    meta_q[gi] <= 1'h0;
                    sync_o[gi] <= 1'h0;
                end
                else
                begin
                    meta_q[gi] <= async_i[gi];
                    sync_o[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate

endmodule : ascan_sync

// *** core/ascan_ctrl.sv ***
// Converter scan control: boundary cells, update stage and APB status
//
// Overview of operation
// - Comparison value on separate bits, bit zero up
// - Bypass select routes channels 0-3 around amplifier
// - Ground enable grounds negative input while true
// - Hold low tracks, hold high freezes
// - Band-gap select feeds converter reference
// - Three-bit negative-side multiplexer select
// - Pass-gate enable opens amplifier pass gate
// - Precharge strobe low precharges output latch
// - Probe enable sends amplifier output to channel 4
// - Supply select uses supply as reference
// - Switched-capacitor clock drives amplifier filter stages
// - Amplifier power enable powers the amplifier
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module ascan_ctrl (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Scan pins from the test controller
    input  wire ascan_pkg::ascan_scan_s scan_i,
    output logic                        tdo,
    // Analog converter macro
    input  wire logic                   comp_i,
    output ascan_pkg::ascan_ctrl_s      ana_o
);
    import ascan_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [ASCAN_SYNC_W-1:0]  sync_w;
    ascan_scan_s              scan_s;
    logic                     comp_s;
    logic                     tck_prev_q;
    logic                     tck_rise;
    logic                     tck_fall;
    logic [ASCAN_CHAIN_W-1:0] chain_q;
    ascan_ctrl_s              chain_word;
    logic                     upd_evt;
    ascan_ctrl_s              ctrl_q;
    logic                     tdo_q;
    logic                     scan_en_q;
    logic                     conflict_q;
    logic                     hold_viol_q;
    logic                     conflict_set;
    logic                     hold_viol_set;
    logic [ASCAN_CNT_W-1:0]   count_q;
    logic [31:0]              prdata_q;
    logic                     pready_q;
    logic                     pslverr_q;
    logic                     apb_done;
    logic                     wr_evt;
    logic [31:0]              rd_data;
    logic                     rd_err;
    logic [63:0]              word_ext;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the test clock is sampled, not used as a clock
    ascan_sync #(
        .W       (ASCAN_SYNC_W)
    ) u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .async_i ({scan_i, comp_i}),
        .sync_o  (sync_w)
    );

    assign scan_s = sync_w[ASCAN_SYNC_W-1:1];
    assign comp_s = sync_w[0];

    // Edge finder on the synchronised test clock
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            tck_prev_q <= 1'h0;
        else
            tck_prev_q <= scan_s.tck;
    end

    assign tck_rise = scan_s.tck & ~tck_prev_q;
    assign tck_fall = ~scan_s.tck & tck_prev_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Scan cells: bit 0 observes the comparator, bits above carry controls
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            chain_q <= {ASCAN_IDLE, 1'h0};
        else if (scan_en_q && tck_rise)
        begin
            if (scan_s.capture_dr)
                chain_q <= {ctrl_q, comp_s};
            else if (scan_s.shift_dr)
                chain_q <= {scan_s.tdi, chain_q[ASCAN_CHAIN_W-1:1]};
        end
    end

    // Serial out changes on the falling test clock edge
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            tdo_q <= 1'h0;
        else if (tck_fall)
            tdo_q <= chain_q[0];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Update stage: the whole control word moves in one cycle
    assign chain_word = chain_q[ASCAN_CHAIN_W-1:1];
    assign upd_evt    = scan_en_q & tck_fall & scan_s.update_dr;

    // Controls are plain levels; the analog macro routes them
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            ctrl_q <= ASCAN_IDLE;
        else if (upd_evt)
            ctrl_q <= chain_word;
    end

    // Field by field onto the macro, bit positions unchanged
    always_comb
    begin
        ana_o                         = ctrl_q;
        ana_o.dac_value               = ctrl_q.dac_value;
        ana_o.amp_bypass_select       = ctrl_q.amp_bypass_select;
        ana_o.neg_input_ground_enable = ctrl_q.neg_input_ground_enable;
        ana_o.sample_hold             = ctrl_q.sample_hold;
        ana_o.bandgap_ref_select      = ctrl_q.bandgap_ref_select;
        ana_o.neg_input_select        = ctrl_q.neg_input_select;
        ana_o.amp_pass_gate_enable    = ctrl_q.amp_pass_gate_enable;
        ana_o.latch_precharge_n       = ctrl_q.latch_precharge_n;
        ana_o.switchcap_probe_enable  = ctrl_q.switchcap_probe_enable;
        ana_o.supply_ref_select       = ctrl_q.supply_ref_select;
        ana_o.switchcap_clock         = ctrl_q.switchcap_clock;
        ana_o.amp_power_enable        = ctrl_q.amp_power_enable;
    end

    assign tdo = tdo_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Hazard watch: two negative paths at once can damage the macro
    assign conflict_set = ctrl_q.neg_input_ground_enable & ctrl_q.neg_bandgap_enable;

    // Hold raised with amplifier powered but its clock low
    assign hold_viol_set = upd_evt & chain_word.sample_hold & ~ctrl_q.sample_hold
                         & chain_word.amp_power_enable & ~chain_word.switchcap_clock;

    // Sticky, write one to clear; a new event wins over the clear
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            conflict_q <= 1'h0;
        else if (conflict_set)
            conflict_q <= 1'h1;
        else if (wr_evt && paddr == ASCAN_OFS_STATUS && pwdata[ASCAN_ST_CONFLICT])
            conflict_q <= 1'h0;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            hold_viol_q <= 1'h0;
        else if (hold_viol_set)
            hold_viol_q <= 1'h1;
        else if (wr_evt && paddr == ASCAN_OFS_STATUS && pwdata[ASCAN_ST_HOLD_VIOL])
            hold_viol_q <= 1'h0;
    end

    // Update counter, wraps; lets software see scan activity
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            count_q <= ASCAN_RST_COUNT;
        else if (upd_evt)
            count_q <= count_q + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB: one wait state so read data leaves a flop
    assign apb_done = psel & penable & pready_q;
    assign wr_evt   = apb_done & pwrite;
    assign word_ext = {{(64 - ASCAN_CTRL_W){1'h0}}, ctrl_q};

    // Read decode; unmapped offsets answer with an error
    always_comb
    begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'h0;
        case (paddr)
            ASCAN_OFS_CTRL:
                rd_data[ASCAN_CTRL_SCAN_EN] = scan_en_q;
            ASCAN_OFS_STATUS:
            begin
                rd_data[ASCAN_ST_CONFLICT]   = conflict_q;
                rd_data[ASCAN_ST_HOLD_VIOL]  = hold_viol_q;
                rd_data[ASCAN_ST_COMP]       = comp_s;
                rd_data[ASCAN_ST_AMP_ACTIVE] = ctrl_q.amp_power_enable;
            end
            ASCAN_OFS_WORD_LO:
                rd_data = word_ext[31:0];
            ASCAN_OFS_WORD_HI:
                rd_data = word_ext[63:32];
            ASCAN_OFS_COUNT:
                rd_data[ASCAN_CNT_W-1:0] = count_q;
            default:
                rd_err = 1'h1;
        endcase
    end

    // Ready rises one cycle into the access phase, then drops
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pready_q  <= 1'h0;
            pslverr_q <= 1'h0;
            prdata_q  <= 32'h0000_0000;
        end
        else if (psel && penable && !pready_q)
        begin
            pready_q  <= 1'h1;
            pslverr_q <= rd_err;
            prdata_q  <= pwrite ? 32'h0000_0000 : rd_data;
        end
        else
        begin
            pready_q  <= 1'h0;
            pslverr_q <= 1'h0;
            prdata_q  <= 32'h0000_0000;
        end
    end

    // Scan enable: off freezes cells and update stage
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            scan_en_q <= ASCAN_RST_SCAN_EN;
        else if (wr_evt && paddr == ASCAN_OFS_CTRL)
            scan_en_q <= pwdata[ASCAN_CTRL_SCAN_EN];
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_idle_after_reset;
        @(posedge clk) sys_rst |=> (ctrl_q == ASCAN_IDLE);
    endproperty
    a_idle_after_reset: assert property (p_idle_after_reset)
        else $error("control word not idle after reset");

    property p_update_loads;
        @(posedge clk) disable iff (sys_rst) upd_evt |=> (ctrl_q == $past(chain_word));
    endproperty
    a_update_loads: assert property (p_update_loads)
        else $error("update did not load the scanned word");

    property p_no_update_stable;
        @(posedge clk) disable iff (sys_rst) !upd_evt |=> $stable(ctrl_q);
    endproperty
    a_no_update_stable: assert property (p_no_update_stable)
        else $error("control word moved without an update");

    property p_dac_follows;
        @(posedge clk) disable iff (sys_rst) upd_evt |=> (ana_o.dac_value == 10'($past(chain_q) >> 21));
    endproperty
    a_dac_follows: assert property (p_dac_follows)
        else $error("comparison value not on its bit lines");

    property p_hold_viol;
        @(posedge clk) disable iff (sys_rst)
            (upd_evt && chain_word.sample_hold && !ctrl_q.sample_hold
             && chain_word.amp_power_enable && !chain_word.switchcap_clock) |=> hold_viol_q [*2];
    endproperty
    a_hold_viol: assert property (p_hold_viol)
        else $error("hold raised with amplifier clock low not flagged");

    property p_conflict;
        @(posedge clk) disable iff (sys_rst)
            (ana_o.neg_input_ground_enable && ana_o.neg_bandgap_enable) |=> conflict_q;
    endproperty
    a_conflict: assert property (p_conflict)
        else $error("negative path conflict not flagged");

    property p_apb_wait;
        @(posedge clk) disable iff (sys_rst) $rose(psel && penable) |-> !pready ##1 pready;
    endproperty
    a_apb_wait: assert property (p_apb_wait)
        else $error("ready not given after one wait state");

    property p_frozen_when_off;
        @(posedge clk) disable iff (sys_rst) !scan_en_q |=> $stable(chain_q) && $stable(ana_o);
    endproperty
    a_frozen_when_off: assert property (p_frozen_when_off)
        else $error("scan cells moved while disabled");

    property p_hold_only_on_update;
        @(posedge clk) disable iff (sys_rst) $changed(ana_o.sample_hold) |-> $past(upd_evt);
    endproperty
    a_hold_only_on_update: assert property (p_hold_only_on_update)
        else $error("hold strobe changed outside an update");

    // Capture must see the live controls and comparator, not a stale copy
    property p_capture_loads;
        @(posedge clk) disable iff (sys_rst)
            (scan_en_q && tck_rise && scan_s.capture_dr) |=> (chain_q == {$past(ctrl_q), $past(comp_s)});
    endproperty
    a_capture_loads: assert property (p_capture_loads)
        else $error("capture did not load controls and comparator");

    property p_shift_enters_top;
        @(posedge clk) disable iff (sys_rst)
            (scan_en_q && tck_rise && !scan_s.capture_dr && scan_s.shift_dr)
            |=> (chain_q[ASCAN_CHAIN_W-1] == $past(scan_s.tdi));
    endproperty
    a_shift_enters_top: assert property (p_shift_enters_top)
        else $error("serial input bit not shifted into the top cell");

    property p_tdo_on_fall;
        @(posedge clk) disable iff (sys_rst) tck_fall |=> (tdo == $past(chain_q[0]));
    endproperty
    a_tdo_on_fall: assert property (p_tdo_on_fall)
        else $error("serial output not taken on the falling test clock");

    property p_count_step;
        @(posedge clk) disable iff (sys_rst) upd_evt |=> (count_q == $past(count_q) + 16'h0001);
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("update counter did not step once per update");

    property p_ready_pulse;
        @(posedge clk) disable iff (sys_rst) pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready stood for more than one cycle");

endmodule : ascan_ctrl

// *** tb/ascan_jtag_model.sv ***
// Test controller model: drives the scan pins and shifts frames through the chain
`timescale 1ns/100ps
module ascan_jtag_model #(
    parameter realtime HALF = 62.5
) (
    // Scan pins towards the block
    output ascan_pkg::ascan_scan_s scan_o,
    // Serial return from the block
    input  wire logic              tdo
);
    import ascan_pkg::*;

    // Test clock stands still between frames
    initial scan_o = '0;

    ////////////////////////////////////////////////////////////////////////////////
    // One frame: capture, 36 shifts, then an optional update cycle
    task automatic frame(input logic [34:0] w, input logic upd, output logic [35:0] cap);
        logic [35:0] sh;
        sh = {w, 1'b0};                 // Comparator cell first, then control bit 0 up
        // Non-blocking, so a pin change that meets a clk edge is seen whole
        scan_o.capture_dr <= 1'b1;
        #HALF scan_o.tck <= 1'b1;
        #HALF scan_o.tck <= 1'b0;
        scan_o.capture_dr <= 1'b0;
        scan_o.shift_dr <= 1'b1;
        for (int i = 0; i < 36; i++)
        begin
            scan_o.tdi <= sh[i];
            #HALF cap[i] = tdo;         // Read just before the shifting edge
            scan_o.tck <= 1'b1;
            #HALF scan_o.tck <= 1'b0;
        end
        // Released data line flips so a stale bit cannot pass for a good one
        scan_o.shift_dr <= 1'b0;
        scan_o.tdi <= ~scan_o.tdi;
        #HALF scan_o.tck <= 1'b1;
        scan_o.update_dr <= upd;        // Raised after the last shift fall: one update
        #HALF scan_o.tck <= 1'b0;
        #HALF scan_o.update_dr <= 1'b0;
    endtask : frame

endmodule : ascan_jtag_model

// *** tb/ascan_ctrl_tb.sv ***
// Self-checking bench for the converter scan control block
`timescale 1ns/100ps
module ascan_ctrl_tb;
    import ascan_pkg::*;

    logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, tdo, comp_i;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    ascan_scan_s scan;
    ascan_ctrl_s ana_o, exp_q, w;
    int          n_fail, checks_done, n_upd, seed;

    ascan_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .scan_i(scan), .tdo(tdo), .comp_i(comp_i), .ana_o(ana_o));
    ascan_jtag_model u_jtag (.scan_o(scan), .tdo(tdo));

    // Free-running system clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Comparison, verdict and bus tasks
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report

    // APB transfer; request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
        begin
            check(1'b0, 1'b1, "bus timeout");
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic experr, input string msg);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0000_0000, rd, err);
        check(64'(rd), 64'(exp), msg);
        check(64'(err), 64'(experr), "read error flag");
    endtask : rdchk

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic experr);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
        check(64'(err), 64'(experr), "write error flag");
    endtask : wr

    // Status expected from the flags, the live comparator level and the expected amplifier power bit
    function automatic logic [31:0] exp_st(input logic conf, input logic hold);
        return (32'(conf) << ASCAN_ST_CONFLICT) | (32'(hold) << ASCAN_ST_HOLD_VIOL)
             | (32'(comp_i) << ASCAN_ST_COMP) | (32'(exp_q.amp_power_enable) << ASCAN_ST_AMP_ACTIVE);
    endfunction : exp_st

    // Scan one frame, then compare chain, outputs and readback registers
    task automatic do_frame(input logic [34:0] wd, input logic upd, input logic en);
        logic [35:0] cap;
        u_jtag.frame(wd, upd, cap);
        repeat (4) @(posedge clk);
        if (en)
            check(64'(cap), 64'({exp_q, comp_i}), "captured chain");
        if (en && upd)
        begin
            exp_q = wd;
            n_upd++;
        end
        check(64'(ana_o), 64'(exp_q), "control word");
        rdchk(ASCAN_OFS_WORD_LO, exp_q[31:0], 1'b0, "word low");
        rdchk(ASCAN_OFS_WORD_HI, 32'(exp_q[34:32]), 1'b0, "word high");
        rdchk(ASCAN_OFS_COUNT, 32'(n_upd[15:0]), 1'b0, "update count");
    endtask : do_frame

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        seed = 34;
        n_fail = 0;
        checks_done = 0;
        n_upd = 0;
        {sys_rst, psel, penable, pwrite, comp_i, paddr, pwdata} = {1'b1, 4'h0, 12'h000, 32'h0000_0000};
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        exp_q = ASCAN_IDLE;
        check(64'(ana_o), 64'(ASCAN_IDLE), "idle levels");
        rdchk(ASCAN_OFS_CTRL, 32'(ASCAN_RST_SCAN_EN), 1'b0, "scan enable");
        rdchk(12'h020, 32'h0000_0000, 1'b1, "unmapped read");
        wr(12'h024, 32'hFFFF_FFFF, 1'b1);
        wr(ASCAN_OFS_WORD_LO, 32'hFFFF_FFFF, 1'b0);
        do_frame(ASCAN_IDLE, 1'b1, 1'b1);
        $display("reset and bus test done");
        // Walking one: every control line alone, neighbours stay low
        for (int i = 0; i < 35; i++)
            do_frame(35'h1 << i, 1'b1, 1'b1);
        // Comparison value corners and random words, amplifier left off
        for (int i = 0; i < 10; i++)
        begin
            w = ASCAN_IDLE;
            w.dac_value = (i < 4) ? 10'(64'h0123_0143_0200_03FF >> (16 * i)) : 10'($random(seed));
            comp_i <= 1'($random(seed));
            do_frame(w, 1'b1, 1'b1);
            w = 35'({$random(seed), $random(seed)});
            w.amp_power_enable = 1'b0;
            do_frame(w, 1'b1, 1'b1);
        end
        do_frame(35'({$random(seed), $random(seed)}), 1'b0, 1'b1);
        $display("scan word test done");
        // Scan disabled: frame must leave everything frozen
        wr(ASCAN_OFS_CTRL, 32'h0000_0000, 1'b0);
        do_frame(35'({$random(seed), $random(seed)}), 1'b1, 1'b0);
        wr(ASCAN_OFS_CTRL, 32'h0000_0001, 1'b0);
        // Hold raised with the filter clock high, then low
        w = ASCAN_IDLE;
        w.sample_hold = 1'b0;
        w.amp_power_enable = 1'b1;
        w.amp_quick_settle = 1'b1;
        w.switchcap_clock = 1'b1;
        do_frame(w, 1'b1, 1'b1);
        wr(ASCAN_OFS_STATUS, 32'h0000_0003, 1'b0);
        w.sample_hold = 1'b1;
        do_frame(w, 1'b1, 1'b1);
        rdchk(ASCAN_OFS_STATUS, exp_st(1'b0, 1'b0), 1'b0, "legal hold");
        w.sample_hold = 1'b0;
        do_frame(w, 1'b1, 1'b1);
        w.sample_hold = 1'b1;
        w.switchcap_clock = 1'b0;
        do_frame(w, 1'b1, 1'b1);
        rdchk(ASCAN_OFS_STATUS, exp_st(1'b0, 1'b1), 1'b0, "hold with clock low");
        wr(ASCAN_OFS_STATUS, 32'h0000_0002, 1'b0);
        // Ground and band-gap on the negative side together
        w = ASCAN_IDLE;
        w.neg_input_ground_enable = 1'b1;
        w.neg_bandgap_enable = 1'b1;
        do_frame(w, 1'b1, 1'b1);
        rdchk(ASCAN_OFS_STATUS, exp_st(1'b1, 1'b0), 1'b0, "path conflict");
        do_frame(ASCAN_IDLE, 1'b1, 1'b1);
        wr(ASCAN_OFS_STATUS, 32'h0000_0001, 1'b0);
        rdchk(ASCAN_OFS_STATUS, exp_st(1'b0, 1'b0), 1'b0, "flags cleared");
        $display("status test done");
        final_report();
    end

endmodule : ascan_ctrl_tb
